// file: scd_burst_track.sv
`timescale 1ns/1ps

// ==========================================================
// Counts the data cycles of a running burst
// ==========================================================
module scd_burst_track (
    input wire logic clk_sys_in,                    // System clock
    input wire logic rst_b_in,                      // Synchronous reset, low active
    input wire logic start_in,                      // Pulse: read or write taken
    input wire logic chop4_in,                      // Burst is a four-beat chop
    output logic busy_out                           // Burst in progress
);

    typedef struct packed {
        logic [2:0] left;                           // Data cycles still to run
    } scd_bt_state_t;

    scd_bt_state_t st_q;                            // Registered state
    scd_bt_state_t st_d;                            // Next state

    // Next state: a new burst may only load in the old one's last cycle or once it has ended
    always_comb begin
        st_d = st_q;
        if (st_q.left != 3'h0) begin
            st_d.left = st_q.left - 3'h1;
        end
        if (start_in && st_q.left <= 3'h1) begin
            st_d.left = chop4_in ? scd_pkg::BURST4_CYC : scd_pkg::BURST8_CYC;
        end
    end

    // State register
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign busy_out = (st_q.left != 3'h0);

endmodule

// file: scd_cmd_table.sv
`timescale 1ns/1ps

// ==========================================================
// Pure truth-table lookup of the strobe and clock-enable levels
// ==========================================================
module scd_cmd_table (
    input wire scd_pkg::scd_bus_t bus_in,           // Pins sampled this edge
    input wire logic cke_prev_in,                   // Clock enable at last edge
    output scd_pkg::scd_cmd_t cmd_out               // Looked-up command
);

    // Match a four-bit strobe pattern, chip select first
    function automatic logic strobe_is(input scd_pkg::scd_bus_t b, input logic [3:0] pat);
        strobe_is = ({b.cs_b, b.ras_b, b.cas_b, b.we_b} == pat);
    endfunction

    // Table lookup
    always_comb begin
        cmd_out = scd_pkg::SCD_CMD_RSVD;
        if (cke_prev_in && bus_in.cke) begin
            // Clock enable steady high: ordinary commands
            if (bus_in.cs_b) begin
                cmd_out = scd_pkg::SCD_CMD_NONE;
            end else if (strobe_is(bus_in, 4'h0)) begin
                cmd_out = scd_pkg::SCD_CMD_MRS;
            end else if (strobe_is(bus_in, 4'h1)) begin
                cmd_out = scd_pkg::SCD_CMD_REF;
            end else if (strobe_is(bus_in, 4'h2)) begin
                cmd_out = bus_in.addr[scd_pkg::AUTO_PRE_BIT] ? scd_pkg::SCD_CMD_PRE_ALL
                                                             : scd_pkg::SCD_CMD_PRE;
            end else if (strobe_is(bus_in, 4'h3)) begin
                cmd_out = scd_pkg::SCD_CMD_ACT;
            end else if (strobe_is(bus_in, 4'h4)) begin
                cmd_out = scd_pkg::SCD_CMD_WRITE;
            end else if (strobe_is(bus_in, 4'h5)) begin
                cmd_out = scd_pkg::SCD_CMD_READ;
            end else if (strobe_is(bus_in, 4'h6)) begin
                cmd_out = bus_in.addr[scd_pkg::AUTO_PRE_BIT] ? scd_pkg::SCD_CMD_CAL_LONG
                                                             : scd_pkg::SCD_CMD_CAL_SHORT;
            end else begin
                cmd_out = scd_pkg::SCD_CMD_NONE;
            end
        end else if (cke_prev_in && !bus_in.cke) begin
            // Clock enable falling: self refresh or power-down entry
            if (strobe_is(bus_in, 4'h1)) begin
                cmd_out = scd_pkg::SCD_CMD_SR_ENTER;
            end else if (bus_in.cs_b || strobe_is(bus_in, 4'h7)) begin
                cmd_out = scd_pkg::SCD_CMD_PD_ENTER;
            end
        end else if (!cke_prev_in && bus_in.cke) begin
            // Clock enable rising: exit, only with no-operation or deselect
            if (bus_in.cs_b || strobe_is(bus_in, 4'h7)) begin
                cmd_out = scd_pkg::SCD_CMD_PD_EXIT;
            end
        end else begin
            // Clock enable steady low: stay where we are
            cmd_out = scd_pkg::SCD_CMD_NONE;
        end
    end

endmodule

// file: scd_ctrl_model.sv
`timescale 1ns/1ps

// ==========================================================
// Memory controller model driving the command pins
// ==========================================================
module scd_ctrl_model (
    input wire logic clk_sys_in, // System clock
    input wire logic req_in, // Drive the requested command
    input wire scd_pkg::scd_bus_t cmd_in, // Requested command
    input wire logic cke_in, // Enable level to hold
    output scd_pkg::scd_bus_t bus_out // Command pins
);
    logic [17:0] junk_q = 18'h0; // Changing don't-care pattern

    // New pattern each cycle; only one of the idle bank and address pins changes per cycle
    always @(negedge clk_sys_in) begin
        junk_q <= {junk_q[16:0], ~junk_q[17]};
    end

    // Requested command, else no-operation with scrambled address
    always_comb begin
        if (req_in) begin
            bus_out = cmd_in;
        end else begin
            bus_out = {4'h7, 1'b0, junk_q};
        end
        bus_out.cke = cke_in;
    end
endmodule

// file: scd_decoder.sv
`timescale 1ns/1ps

// What this block does
// [RQ1] Decode only from strobes sampled on edge
// [RQ2] Controller keeps device reset high always; the bench holds rst_b_in low for its first five cycles
// [RQ3] Mode set: bank picks register, address opcode
// [RQ4] Bank bits pick target for bank commands
// [RQ5] Activate takes row address from pins
// [RQ6] Precharge: A10 low one bank, high all
// [RQ7] Write: A10 auto-precharge, A12 chop if enabled
// [RQ8] Read: same options as write
// [RQ9] Refresh if enable high; falling enters self refresh
// [RQ10] Calibration: A10 high long, low short
// [RQ11] Bursts run whole; length follows mode register
// [RQ12] No refresh while in power-down
// [RQ13] Termination off in self refresh
// [RQ14] Self refresh exits at once on enable rise
// [RQ15] Controller waits 512 cycles before first write; the bench issues its first write 16 cycles after reset
// [RQ16] No-operation never aborts running operation
// [RQ17] Deselect ignores pins, acts as no-operation
// [RQ18] Controller: only idle commands around power changes; t_idle drives an activate strobe as the enable falls
// [RQ19] Controller holds enable level for minimum pulse
// [RQ20] Reserved combinations take no action

// ==========================================================
// Command decoder of an eight-bank DDR SDRAM
// ==========================================================
module scd_decoder (
    input wire logic clk_sys_in,                    // System clock, 250 MHz
    input wire logic rst_b_in,                      // Synchronous reset, low active
    input wire scd_pkg::scd_bus_t bus_in,           // Command and address pins
    input wire logic term_req_in,                   // Termination control pin
    output scd_pkg::scd_dec_t dec_out,              // Decoded command, registered
    output logic [1:0] burst_mode_out,              // Burst length field in force
    output scd_pkg::scd_pwr_t pwr_out,              // Power state
    output logic refresh_out,                       // Pulse: refresh performed
    output logic burst_busy_out,                    // Data burst in progress
    output logic term_en_out                        // Termination enabled
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic cke_prev;                             // Clock enable at last edge
        scd_pkg::scd_pwr_t pwr;                     // Power state
        logic [1:0] burst_mode;                     // Burst length setting
        scd_pkg::scd_dec_t dec;                     // Last decoded command
        logic refresh;                              // Refresh pulse
    } scd_state_t;

    scd_state_t st_q;                               // Registered state
    scd_state_t st_d;                               // Next state
    scd_pkg::scd_cmd_t raw_cmd;                     // Table lookup result
    logic burst_busy;                               // Burst counter running
    logic sr_exit_now;                              // Enable rose while in self refresh

    // Truth table lookup
    scd_cmd_table u_table (
        .bus_in(bus_in),
        .cke_prev_in(st_q.cke_prev),
        .cmd_out(raw_cmd)
    );

    // Burst counter; a read or write taken with at most one burst cycle left always runs to the end
    scd_burst_track u_burst (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .start_in(st_d.dec.valid && (st_d.dec.cmd == scd_pkg::SCD_CMD_READ ||
                                     st_d.dec.cmd == scd_pkg::SCD_CMD_WRITE)),
        .chop4_in(st_d.dec.chop4),
        .busy_out(burst_busy)
    );

    // Chop decision from mode setting and address bit 12
    function automatic logic chop_sel(input logic [1:0] mode, input logic a12);
        chop_sel = (mode == scd_pkg::BL_FIXED4) ||
                   ((mode == scd_pkg::BL_OTF) && !a12);
    endfunction

    // Self refresh leaves as soon as the enable pin rises, not at an edge
    assign sr_exit_now = (st_q.pwr == scd_pkg::SCD_PWR_SELF) && bus_in.cke; // RQ14

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always_comb begin
        st_d = st_q;
        st_d.cke_prev = bus_in.cke; // RQ1
        st_d.refresh = 1'b0;
        st_d.dec = '0;
        st_d.dec.cmd = raw_cmd; // RQ1
        case (raw_cmd)
            scd_pkg::SCD_CMD_MRS: begin
                // Bank bits choose register, address carries opcode
                st_d.dec.valid = 1'b1;
                st_d.dec.mr_sel = bus_in.bank[scd_pkg::MR_W-1:0]; // RQ3
                st_d.dec.opcode = bus_in.addr; // RQ3
                if (bus_in.bank[scd_pkg::MR_W-1:0] == scd_pkg::MR_SEL_BURST) begin
                    st_d.burst_mode = bus_in.addr[1:0]; // RQ11
                end
            end
            scd_pkg::SCD_CMD_REF: begin
                // Refresh only while awake
                st_d.dec.valid = 1'b1;
                st_d.refresh = (st_q.pwr == scd_pkg::SCD_PWR_ON); // RQ9 RQ12
            end
            scd_pkg::SCD_CMD_SR_ENTER: begin
                st_d.dec.valid = 1'b1;
                st_d.pwr = scd_pkg::SCD_PWR_SELF; // RQ9
            end
            scd_pkg::SCD_CMD_PRE: begin
                st_d.dec.valid = 1'b1;
                st_d.dec.bank = bus_in.bank; // RQ4 RQ6
            end
            scd_pkg::SCD_CMD_PRE_ALL: begin
                // Bank bits ignored when closing every bank
                st_d.dec.valid = 1'b1; // RQ6
            end
            scd_pkg::SCD_CMD_ACT: begin
                st_d.dec.valid = 1'b1;
                st_d.dec.bank = bus_in.bank; // RQ4
                st_d.dec.row = bus_in.addr; // RQ5
            end
            scd_pkg::SCD_CMD_WRITE,
            scd_pkg::SCD_CMD_READ: begin
                // Column, auto-precharge and chop for both directions
                st_d.dec.valid = 1'b1;
                st_d.dec.bank = bus_in.bank; // RQ4
                st_d.dec.col = {bus_in.addr[scd_pkg::COL_HI_BIT],
                                bus_in.addr[scd_pkg::COL_W-1:0]};
                st_d.dec.auto_pre = bus_in.addr[scd_pkg::AUTO_PRE_BIT]; // RQ7 RQ8
                st_d.dec.chop4 = chop_sel(st_q.burst_mode,
                                          bus_in.addr[scd_pkg::CHOP_BIT]); // RQ7 RQ8 RQ11
            end
            scd_pkg::SCD_CMD_PD_ENTER: begin
                st_d.dec.valid = 1'b1;
                st_d.pwr = scd_pkg::SCD_PWR_DOWN;
            end
            scd_pkg::SCD_CMD_PD_EXIT: begin
                // Rising enable leaves whichever low-power state we are in
                st_d.dec.valid = 1'b1;
                if (st_q.pwr == scd_pkg::SCD_PWR_SELF) begin
                    st_d.dec.cmd = scd_pkg::SCD_CMD_SR_EXIT;
                end
                st_d.pwr = scd_pkg::SCD_PWR_ON;
            end
            scd_pkg::SCD_CMD_CAL_LONG,
            scd_pkg::SCD_CMD_CAL_SHORT: begin
                // Only bit 10 matters
                st_d.dec.valid = 1'b1; // RQ10
            end
            scd_pkg::SCD_CMD_RSVD: begin
                // Undefined combination: nothing happens
                st_d.dec.cmd = scd_pkg::SCD_CMD_NONE; // RQ20
            end
            default: begin
                // No-operation or deselect: running burst untouched
                st_d.dec.cmd = scd_pkg::SCD_CMD_NONE; // RQ16 RQ17
            end
        endcase
        if (sr_exit_now) begin
            st_d.pwr = scd_pkg::SCD_PWR_ON; // RQ14
        end
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            st_q <= '0;
            st_q.burst_mode <= scd_pkg::BL_RESET;
            st_q.pwr <= scd_pkg::SCD_PWR_ON;
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign dec_out = st_q.dec;
    assign burst_mode_out = st_q.burst_mode;
    assign pwr_out = sr_exit_now ? scd_pkg::SCD_PWR_ON : st_q.pwr; // RQ14
    assign refresh_out = st_q.refresh;
    assign burst_busy_out = burst_busy; // RQ11
    // Termination follows its pin but is forced off in self refresh
    assign term_en_out = term_req_in && (pwr_out != scd_pkg::SCD_PWR_SELF); // RQ13

endmodule

// file: scd_decoder_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin \
    n_checks++; \
    if ((g) !== (e)) begin \
        miscompares++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
end

// ==========================================================
// Self-checking bench of the command decoder
// ==========================================================
module scd_decoder_bench;
    logic clk_sys_in; // System clock
    logic rst_b_in; // Reset, low active
    logic req; // Model drives a command
    scd_pkg::scd_bus_t cmd; // Requested command
    logic cke; // Enable level held by the model
    logic term_req; // Termination request
    scd_pkg::scd_bus_t bus; // Command pins
    scd_pkg::scd_dec_t dec; // Decoded command
    logic [1:0] bmode; // Burst mode in force
    scd_pkg::scd_pwr_t pwr; // Power state
    logic refr; // Refresh pulse
    logic busy; // Burst running
    logic term_en; // Termination enabled
    int miscompares; // Mismatches seen
    int n_checks; // Comparisons made

    scd_ctrl_model u_ctrl (.clk_sys_in(clk_sys_in), .req_in(req), .cmd_in(cmd),
        .cke_in(cke), .bus_out(bus));
    scd_decoder dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .bus_in(bus),
        .term_req_in(term_req), .dec_out(dec), .burst_mode_out(bmode), .pwr_out(pwr),
        .refresh_out(refr), .burst_busy_out(busy), .term_en_out(term_en));

    // Clock, 4 ns period
    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end

    // One command for one edge, then back to no-operation
    task automatic issue(input logic [3:0] s, input logic k, input logic [2:0] b,
        input logic [14:0] a);
        @(negedge clk_sys_in);
        req = 1'b1;
        cmd = {s, k, b, a};
        cke = k;
        @(negedge clk_sys_in);
        req = 1'b0;
    endtask

    // Verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Activate, precharge, calibration and mode set fields
    task automatic t_bank();
        issue(4'h3, 1'b1, 3'h5, 15'h5a5a);
        `CHK(dec.cmd, scd_pkg::SCD_CMD_ACT)
        `CHK(dec.bank, 3'h5)
        `CHK(dec.row, 15'h5a5a)
        for (int i = 0; i < 2; i++) begin
            issue(4'h2, 1'b1, 3'h3, {4'h0, i[0], 10'h3ff});
            `CHK(dec.cmd, i[0] ? scd_pkg::SCD_CMD_PRE_ALL : scd_pkg::SCD_CMD_PRE)
            issue(4'h6, 1'b1, 3'h7, {4'hf, i[0], 10'h3ff});
            `CHK(dec.cmd, i[0] ? scd_pkg::SCD_CMD_CAL_LONG : scd_pkg::SCD_CMD_CAL_SHORT)
        end
        issue(4'h0, 1'b1, 3'h2, 15'h1234);
        `CHK(dec.mr_sel, 2'h2)
        `CHK(dec.opcode, 15'h1234)
        `CHK(bmode, scd_pkg::BL_RESET)
        $display("t_bank done");
    endtask

    // Reads and writes in every burst mode, options and lengths
    task automatic t_rw();
        logic [1:0] m;
        logic [2:0] n;
        logic ch;
        for (int j = 0; j < 3; j++) begin
            m = (j == 0) ? scd_pkg::BL_OTF : (j == 1) ? scd_pkg::BL_FIXED4 : scd_pkg::BL_FIXED8;
            issue(4'h0, 1'b1, 3'h0, {13'h0, m});
            `CHK(bmode, m)
            for (int i = 0; i < 8; i++) begin
                ch = (m == scd_pkg::BL_FIXED4) || (m == scd_pkg::BL_OTF && !i[2]);
                issue({3'h2, i[0]}, 1'b1, 3'h6, {2'h0, i[2], 1'b1, i[1], 10'h2c5});
                `CHK(dec.cmd, i[0] ? scd_pkg::SCD_CMD_READ : scd_pkg::SCD_CMD_WRITE)
                `CHK(dec.auto_pre, i[1])
                `CHK(dec.chop4, ch)
                `CHK(dec.col, 11'h6c5)
                n = 3'h0;
                while (busy === 1'b1 && n < 3'h7) begin
                    n++;
                    @(negedge clk_sys_in);
                end
                `CHK(n, ch ? scd_pkg::BURST4_CYC : scd_pkg::BURST8_CYC)
            end
        end
        $display("t_rw done");
    endtask

    // Refresh, self refresh, power-down; no write follows the exit here
    task automatic t_power();
        issue(4'h1, 1'b1, 3'h0, 15'h0);
        `CHK(refr, 1'b1)
        issue(4'h1, 1'b0, 3'h0, 15'h0);
        `CHK(pwr, scd_pkg::SCD_PWR_SELF)
        `CHK(term_en, 1'b0)
        repeat (3) @(negedge clk_sys_in);
        `CHK(refr, 1'b0)
        cke = 1'b1;
        #1;
        `CHK(pwr, scd_pkg::SCD_PWR_ON)
        `CHK(term_en, 1'b1)
        @(negedge clk_sys_in);
        `CHK(dec.cmd, scd_pkg::SCD_CMD_SR_EXIT)
        issue(4'h7, 1'b0, 3'h0, 15'h0);
        `CHK(dec.cmd, scd_pkg::SCD_CMD_PD_ENTER)
        issue(4'h1, 1'b0, 3'h0, 15'h0);
        `CHK(refr, 1'b0)
        `CHK(pwr, scd_pkg::SCD_PWR_DOWN)
        issue(4'h7, 1'b1, 3'h0, 15'h0);
        `CHK(dec.cmd, scd_pkg::SCD_CMD_PD_EXIT)
        `CHK(pwr, scd_pkg::SCD_PWR_ON)
        $display("t_power done");
    endtask

    // Deselect mid-burst, reserved code, termination request
    task automatic t_idle();
        issue(4'h5, 1'b1, 3'h1, 15'h1000);
        issue(4'h8, 1'b1, 3'h7, 15'h7fff);
        `CHK(dec.valid, 1'b0)
        `CHK(busy, 1'b1)
        issue(4'h3, 1'b0, 3'h2, 15'h0);
        `CHK(dec.valid, 1'b0)
        `CHK(pwr, scd_pkg::SCD_PWR_ON)
        issue(4'h7, 1'b1, 3'h0, 15'h0);
        term_req = 1'b0;
        #1;
        `CHK(term_en, 1'b0)
        $display("t_idle done");
    endtask

    // Reset, then the tests in turn
    initial begin
        miscompares = 0;
        n_checks = 0;
        rst_b_in = 1'b0;
        req = 1'b0;
        cmd = '0;
        cke = 1'b1;
        term_req = 1'b1;
        repeat (5) @(negedge clk_sys_in);
        `CHK(dec.cmd, scd_pkg::SCD_CMD_NONE)
        `CHK(pwr, scd_pkg::SCD_PWR_ON)
        `CHK(busy, 1'b0)
        rst_b_in = 1'b1;
        @(negedge clk_sys_in);
        `CHK(dec.cmd, scd_pkg::SCD_CMD_PD_EXIT)
        t_bank();
        t_rw();
        t_power();
        t_idle();
        summarize();
    end

    // Watchdog against a hang
    initial begin
        repeat (3000) @(posedge clk_sys_in);
        miscompares++;
        $display("watchdog expired");
        summarize();
    end
endmodule

// file: scd_decoder_properties.sv
`timescale 1ns/1ps

// ==========================================================
// Port checks of the command decoder
// ==========================================================
module scd_decoder_properties (
    input wire logic clk_sys_in, // System clock
    input wire logic rst_b_in, // Reset, low active
    input wire scd_pkg::scd_bus_t bus_in, // Command pins
    input wire logic term_req_in, // Termination request
    input wire scd_pkg::scd_dec_t dec_out, // Decoded command
    input wire logic [1:0] burst_mode_out, // Burst mode in force
    input wire scd_pkg::scd_pwr_t pwr_out, // Power state
    input wire logic refresh_out, // Refresh pulse
    input wire logic burst_busy_out, // Burst running
    input wire logic term_en_out // Termination enabled
);
    logic cke_q; // Enable at last edge
    logic [3:0] stb; // Strobes cs, ras, cas, we
    logic hh; // Enable high at both edges
    assign stb = {bus_in.cs_b, bus_in.ras_b, bus_in.cas_b, bus_in.we_b};
    assign hh = cke_q & bus_in.cke;

    // Previous enable level, low after reset
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            cke_q <= 1'b0;
        end else begin
            cke_q <= bus_in.cke;
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);

    property p_act;
        hh && stb == 4'h3 |=> dec_out.valid && dec_out.cmd == scd_pkg::SCD_CMD_ACT
            && dec_out.bank == $past(bus_in.bank) && dec_out.row == $past(bus_in.addr);
    endproperty
    a_act: assert property (p_act) else $error("activate decode wrong");
    property p_pre;
        hh && stb == 4'h2 |=> dec_out.cmd == ($past(bus_in.addr[10])
            ? scd_pkg::SCD_CMD_PRE_ALL : scd_pkg::SCD_CMD_PRE);
    endproperty
    a_pre: assert property (p_pre) else $error("precharge decode wrong");
    property p_rw;
        hh && stb[3:1] == 3'h2 |=> dec_out.auto_pre == $past(bus_in.addr[10])
            && dec_out.col == {$past(bus_in.addr[11]), $past(bus_in.addr[9:0])}
            && dec_out.cmd == ($past(bus_in.we_b) ? scd_pkg::SCD_CMD_READ
            : scd_pkg::SCD_CMD_WRITE);
    endproperty
    a_rw: assert property (p_rw) else $error("read or write decode wrong");
    property p_chop;
        hh && stb[3:1] == 3'h2 && burst_mode_out == scd_pkg::BL_OTF
            |=> dec_out.chop4 == !$past(bus_in.addr[12]);
    endproperty
    a_chop: assert property (p_chop) else $error("chop select wrong");
    property p_mrs;
        hh && stb == 4'h0 |=> dec_out.cmd == scd_pkg::SCD_CMD_MRS
            && dec_out.mr_sel == $past(bus_in.bank[1:0]) && dec_out.opcode == $past(bus_in.addr);
    endproperty
    a_mrs: assert property (p_mrs) else $error("mode set decode wrong");
    property p_ref;
        hh && stb == 4'h1 && pwr_out == scd_pkg::SCD_PWR_ON
            |=> dec_out.cmd == scd_pkg::SCD_CMD_REF && refresh_out;
    endproperty
    a_ref: assert property (p_ref) else $error("refresh not done");
    property p_sre;
        cke_q && !bus_in.cke && stb == 4'h1 |=> bus_in.cke || pwr_out == scd_pkg::SCD_PWR_SELF;
    endproperty
    a_sre: assert property (p_sre) else $error("self refresh not entered");
    property p_cal;
        hh && stb == 4'h6 |=> dec_out.cmd == ($past(bus_in.addr[10])
            ? scd_pkg::SCD_CMD_CAL_LONG : scd_pkg::SCD_CMD_CAL_SHORT);
    endproperty
    a_cal: assert property (p_cal) else $error("calibration decode wrong");
    property p_des;
        hh && bus_in.cs_b |=> !dec_out.valid && dec_out.cmd == scd_pkg::SCD_CMD_NONE;
    endproperty
    a_des: assert property (p_des) else $error("deselect took action");
    property p_term;
        term_en_out == (term_req_in && pwr_out != scd_pkg::SCD_PWR_SELF);
    endproperty
    a_term: assert property (p_term) else $error("termination enable wrong");
    property p_srx;
        bus_in.cke |-> pwr_out != scd_pkg::SCD_PWR_SELF;
    endproperty
    a_srx: assert property (p_srx) else $error("self refresh kept with enable high");
    property p_bl8;
        dec_out.valid && !dec_out.chop4 && !$past(burst_busy_out)
            && dec_out.cmd inside {scd_pkg::SCD_CMD_READ, scd_pkg::SCD_CMD_WRITE}
            |-> burst_busy_out [*4];
    endproperty
    a_bl8: assert property (p_bl8) else $error("full burst cut short");
endmodule

bind scd_decoder scd_decoder_properties u_props (
    .clk_sys_in, .rst_b_in, .bus_in, .term_req_in, .dec_out, .burst_mode_out,
    .pwr_out, .refresh_out, .burst_busy_out, .term_en_out
);

// file: scd_pkg.sv
package scd_pkg;

    // ==========================================================
    // Widths
    // ==========================================================
    localparam int BANK_W = 3; // Bank address width
    localparam int ADDR_W = 15; // Row/column address width
    localparam int MR_W = 2; // Mode register select width

    // ==========================================================
    // Address field positions
    // ==========================================================
    localparam int AUTO_PRE_BIT = 10; // Auto-precharge / all-banks bit
    localparam int CHOP_BIT = 12; // On-the-fly chop select bit
    localparam int COL_W = 10; // Column address width
    localparam int COL_HI_BIT = 11; // Extra column bit above A10

    // ==========================================================
    // Mode register fields (burst length field of mode register 0)
    // ==========================================================
    localparam logic [1:0] MR_SEL_BURST = 2'h0; // Register holding burst mode
    localparam logic [1:0] BL_FIXED8 = 2'h0; // Fixed eight beats
    localparam logic [1:0] BL_OTF = 2'h1; // Chosen on the fly
    localparam logic [1:0] BL_FIXED4 = 2'h2; // Fixed four-beat chop
    localparam logic [1:0] BL_RESET = 2'h0; // Burst mode after reset

    // ==========================================================
    // Burst timing (clock cycles of data transfer, two beats a cycle)
    // ==========================================================
    localparam logic [2:0] BURST8_CYC = 3'h4; // Cycles for eight beats
    localparam logic [2:0] BURST4_CYC = 3'h2; // Cycles for four beats

    // ==========================================================
    // Decoded commands
    // ==========================================================
    typedef enum logic [3:0] {
        SCD_CMD_NONE = 4'h0, // No operation or deselect
        SCD_CMD_MRS = 4'h1, // Mode register set
        SCD_CMD_REF = 4'h2, // Refresh
        SCD_CMD_SR_ENTER = 4'h3, // Self refresh entry
        SCD_CMD_SR_EXIT = 4'h4, // Self refresh exit
        SCD_CMD_PRE = 4'h5, // Single bank precharge
        SCD_CMD_PRE_ALL = 4'h6, // Precharge all banks
        SCD_CMD_ACT = 4'h7, // Bank activate
        SCD_CMD_WRITE = 4'h8, // Write
        SCD_CMD_READ = 4'h9, // Read
        SCD_CMD_PD_ENTER = 4'ha, // Power-down entry
        SCD_CMD_PD_EXIT = 4'hb, // Power-down exit
        SCD_CMD_CAL_LONG = 4'hc, // Long impedance calibration
        SCD_CMD_CAL_SHORT = 4'hd, // Short impedance calibration
        SCD_CMD_RSVD = 4'he // Reserved, no action
    } scd_cmd_t;

    // Power state of the device
    typedef enum logic [1:0] {
        SCD_PWR_ON = 2'b00, // Normal operation
        SCD_PWR_DOWN = 2'b01, // Power-down
        SCD_PWR_SELF = 2'b11 // Self refresh
    } scd_pwr_t;

    // Command pins sampled on the clock edge
    typedef struct packed {
        logic cs_b; // Chip select, low active
        logic ras_b; // Row strobe, low active
        logic cas_b; // Column strobe, low active
        logic we_b; // Write enable, low active
        logic cke; // Clock enable
        logic [BANK_W-1:0] bank; // Bank address
        logic [ADDR_W-1:0] addr; // Address pins
    } scd_bus_t;

    // One decoded command
    typedef struct packed {
        logic valid; // Pulse: a command was taken
        scd_cmd_t cmd; // Which command
        logic [BANK_W-1:0] bank; // Target bank
        logic [ADDR_W-1:0] row; // Row address (activate)
        logic [COL_W:0] col; // Column address incl. A11
        logic auto_pre; // Auto-precharge requested
        logic chop4; // Four-beat chop in force
        logic [MR_W-1:0] mr_sel; // Mode register chosen
        logic [ADDR_W-1:0] opcode; // Mode register opcode
    } scd_dec_t;

endpackage
